/* File: bench/sg_cell_model.sv */
// load cell and tare button model facing the readout block
`timescale 1ns/1ps
`default_nettype none
module sg_cell_model (
  input  wire logic                 clk_i,
  input  wire logic                 conv_start_i,
  input  wire logic                 press_i,
  output var sg_tare_pkg::sample_t  sample_o,
  output logic                      tare_pin_o
);
  import sg_tare_pkg::*;
  // ==========================================
  // results
  logic [2:0] step = 3'h0;
  logic       tog  = 1'b0;
  always_ff @(posedge clk_i) begin
    tog <= ~tog;
    if (conv_start_i) begin
      step <= 3'h4;
    end else if (step != 3'h0) begin
      step <= step - 3'h1;
    end
  end
  // idle data toggles so a stale value is never mistaken for a result
  always_comb begin
    sample_o.valid = (step != 3'h0);
    sample_o.ch    = 2'(3'h4 - step);
    sample_o.data  = sample_o.valid ? 24'(100 * (5 - int'(step))) : {24{tog}};
  end
  assign tare_pin_o = press_i;
endmodule
`default_nettype wire

/* File: bench/sg_tare_sva.sv */
// port checks of the load cell readout and tare block
`timescale 1ns/1ps
`default_nettype none
module sg_tare_sva (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic                  conv_start_o,
  input wire logic                  burnout_o,
  input wire logic                  tare_pin_i,
  input wire logic                  dout_o,
  input wire logic                  cal_mode_o,
  input wire sg_tare_pkg::adc_cfg_t adc_cfg_o
);
  import sg_tare_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // ==========================================
  // properties
  property p_rdy;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_err;
    pslverr_o |-> pready_o;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_conv_off;
    !adc_cfg_o.enable [*2] |-> !conv_start_o;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("conversion while off");
  property p_conv_gap;
    conv_start_o |=> !conv_start_o [*8];
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conversion pace");
  property p_burn;
    $rose(burnout_o) |-> adc_cfg_o.burnout;
  endproperty
  a_burn: assert property (p_burn) else $error("check while disabled");
  // a toggle needs a held pin, so a bounce cannot flip the mode
  property p_cal_pin;
    $changed(cal_mode_o) |-> $past(tare_pin_i, 2) == $past(tare_pin_i, 8);
  endproperty
  a_cal_pin: assert property (p_cal_pin) else $error("mode toggled on moving pin");
  property p_fb_on;
    $rose(dout_o) && cal_mode_o |-> dout_o [*8];
  endproperty
  a_fb_on: assert property (p_fb_on) else $error("feedback pulse short");
  property p_fb_off;
    $fell(dout_o) && cal_mode_o |-> !dout_o [*8];
  endproperty
  a_fb_off: assert property (p_fb_off) else $error("feedback gap short");
  c_cal: cover property ($rose(cal_mode_o));
  c_burn: cover property ($rose(burnout_o));
  c_err: cover property (pslverr_o);
endmodule
bind sg_tare sg_tare_sva sva (
  .clk_i       (clk_i),
  .reset_i     (reset_i),
  .psel_i      (psel_i),
  .penable_i   (penable_i),
  .pready_o    (pready_o),
  .pslverr_o   (pslverr_o),
  .conv_start_o(conv_start_o),
  .burnout_o   (burnout_o),
  .tare_pin_i  (tare_pin_i),
  .dout_o      (dout_o),
  .cal_mode_o  (cal_mode_o),
  .adc_cfg_o   (adc_cfg_o)
);
`default_nettype wire

/* File: bench/tb_sg_tare.sv */
// self-checking bench of the load cell readout and tare block
`include "sg_tare_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_sg_tare;
  import sg_tare_pkg::*;
  // short clock so a millisecond is ten cycles
  localparam int HZ = 10000;
  localparam int MS = HZ / 1000;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        press = 1'b0;
  logic        dout_ctl_i = 1'b0;
  logic        ilk_ctl_i = 1'b1;
  logic        pready_o, pslverr_o, conv_start_o, burnout_o, tare_pin, dout_o, ilk_o, cal_mode_o;
  logic [31:0] prdata_o;
  sample_t     sample;
  adc_cfg_t    adc_cfg_o;
  logic        burn_q = 1'b1;
  logic        dout_q = 1'b1;
  int          failures = 0;
  int          n_compared = 0;
  int          convs = 0;
  int          burns = 0;
  int          rises = 0;
  sg_cell_model cells (
    .clk_i       (clk_i),
    .conv_start_i(conv_start_o),
    .press_i     (press),
    .sample_o    (sample),
    .tare_pin_o  (tare_pin)
  );
  sg_tare #(.CLK_HZ(HZ)) dut (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .paddr_i     (paddr_i),
    .pwdata_i    (pwdata_i),
    .prdata_o    (prdata_o),
    .pready_o    (pready_o),
    .pslverr_o   (pslverr_o),
    .sample_i    (sample),
    .adc_cfg_o   (adc_cfg_o),
    .conv_start_o(conv_start_o),
    .burnout_o   (burnout_o),
    .tare_pin_i  (tare_pin),
    .dout_ctl_i  (dout_ctl_i),
    .ilk_ctl_i   (ilk_ctl_i),
    .dout_o      (dout_o),
    .ilk_o       (ilk_o),
    .cal_mode_o  (cal_mode_o)
  );
  // ==========================================
  // helpers
  initial begin
    forever begin
      #2.5 clk_i = ~clk_i;
    end
  end
  always @(posedge clk_i) begin
    convs += int'(conv_start_o);
    burns += int'(burnout_o && !burn_q);
    rises += int'(dout_o && !dout_q);
    burn_q <= burnout_o;
    dout_q <= dout_o;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1);
    chk("pready_wait", 32'd1, 32'(n));
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask
  task automatic wait_ms(input int ms);
    repeat (ms * MS) @(posedge clk_i);
  endtask
  task automatic push(input int hold, input int rest);
    press <= 1'b1;
    wait_ms(hold);
    press <= 1'b0;
    wait_ms(rest);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    repeat (3) @(posedge clk_i);
    chk("adc_cfg", 32'(adc_cfg_t'{1'b1, 3'h0, 4'h0, 3'h0, 1'b1}), 32'(adc_cfg_o));
    rd("ctrl", `OFF_CTRL, `CTRL_RST);
    rd("burn", `OFF_BURN, 32'(`BURN_RST));
    rd("tcfg", `OFF_TCFG, `TCFG_RST);
    rd("times", `OFF_TIMES, `TIMES_RST);
    rd("sens", `OFF_CH_BASE, `SENS_RST);
    rd("cap", 8'h44, `CAP_RST);
    rd("units", 8'h48, 32'h0);
    rd("cmd", `OFF_CMD, 32'h0);
    apb(1'b0, 8'h2C, 32'h0, q, e);
    chk("slverr", 32'h1, 32'(e));
    chk("err_data", 32'h0, q);
    $display("test reset done");
  endtask
  task automatic t_config;
    int c;
    wr(`OFF_CTRL, 32'h0000_0F29);
    repeat (60) @(posedge clk_i);
    chk("adc_cfg", 32'(adc_cfg_t'{1'b1, 3'h4, 4'h2, 3'h7, 1'b1}), 32'(adc_cfg_o));
    c = convs;
    repeat (500) @(posedge clk_i);
    chk("conv_rate", 32'd20, 32'(convs - c));
    wr(`OFF_CTRL, 32'h0000_0F28);
    repeat (5) @(posedge clk_i);
    c = convs;
    repeat (500) @(posedge clk_i);
    chk("conv_off", 32'd0, 32'(convs - c));
    wr(`OFF_CTRL, 32'h0000_0729);
    c = burns;
    wait_ms(2100);
    chk("burn_off", 32'd0, 32'(burns - c));
    wr(`OFF_CTRL, 32'h0000_0F29);
    $display("test config done");
  endtask
  task automatic t_weight;
    for (int ch = 0; ch < 4; ch++) begin
      wr(8'(`OFF_CH_BASE + 16 * ch), 32'd1000);
      wr(8'(`OFF_CH_BASE + 16 * ch + 4), 32'd1000);
    end
    wr(8'h78, 32'h1);
    wait_ms(20);
    for (int ch = 0; ch < 3; ch++) begin
      rd("weight", 8'(`OFF_WEIGHT + 4 * ch), 32'(100 * (ch + 1)));
    end
    rd("pounds", 8'h3C, 32'((64'sd400 * `LB_PER_KG_Q16) >>> 16));
    $display("test weight done");
  endtask
  task automatic t_zero;
    wr(8'h48, 32'h100);
    wait_ms(5);
    rd("az_weight", 8'h30, 32'h0);
    rd("az_offset", 8'h4C, 32'd100);
    wr(`OFF_CMD, 32'h5);
    wait_ms(5);
    rd("cmd_zero", 8'h34, 32'h0);
    wr(8'h6C, 32'd100);
    wait_ms(5);
    rd("ofs_write", 8'h38, 32'd200);
    $display("test zero done");
  endtask
  task automatic t_cal;
    int r;
    int b;
    b = burns;
    wr(`OFF_TCFG, 32'h0000_0104);
    wr(`OFF_TIMES, 32'h0004_0005);
    dout_ctl_i <= 1'b1;
    push(3, 10);
    chk("short_out", 32'h0, 32'(cal_mode_o));
    chk("dout_norm", 32'h1, 32'(dout_o));
    dout_ctl_i <= 1'b0;
    push(12, 2);
    chk("cal_on", 32'h1, 32'(cal_mode_o));
    chk("fb_enter", 32'h1, 32'(dout_o));
    dout_ctl_i <= 1'b1;
    wait_ms(690);
    chk("fb_hold", 32'h1, 32'(dout_o));
    chk("ilk_free", 32'h1, 32'(ilk_o));
    wait_ms(100);
    chk("fb_over", 32'h0, 32'(dout_o));
    wait_ms(500);
    r = rises;
    push(3, 2);
    push(3, 2);
    push(3, 2);
    wait_ms(1700);
    chk("fb_pulses", 32'd3, 32'(rises - r));
    rd("staged", 8'h38, 32'd200);
    dout_ctl_i <= 1'b0;
    push(12, 2);
    chk("cal_off", 32'h0, 32'(cal_mode_o));
    chk("fb_exit", 32'h1, 32'(dout_o));
    dout_ctl_i <= 1'b1;
    wait_ms(1100);
    chk("dout_back", 32'h1, 32'(dout_o));
    rd("committed", 8'h38, 32'h0);
    chk("burn_on", 32'h1, 32'(burns - b >= 2));
    $display("test cal done");
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_config();
    t_weight();
    t_zero();
    t_cal();
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire

/* File: include/sg_tare_defines.svh */
// register offsets, field positions, reset values and timing figures
`ifndef SG_TARE_DEFINES_SVH
`define SG_TARE_DEFINES_SVH
`define OFF_CTRL     8'h00
`define OFF_BURN     8'h04
`define OFF_TCFG     8'h08
`define OFF_TIMES    8'h0C
`define OFF_CMD      8'h10
`define OFF_STAT     8'h14
`define OFF_CONST1   8'h18
`define OFF_CONST2   8'h1C
`define OFF_WEIGHT   8'h30
`define OFF_CH_BASE  8'h40
`define CH_SENS      2'h0
`define CH_CAP       2'h1
`define CH_CFG       2'h2
`define CH_OFS       2'h3
`define CTRL_RST     32'h0000_0801
`define BURN_RST     16'h0001
`define TCFG_RST     32'h0000_0A00
`define TIMES_RST    32'h03E8_0BB8
`define SENS_RST     32'h0000_07D0
`define CAP_RST      32'h0000_03E8
`define FB_LONG_MS   750
`define FB_PULSE_MS  250
`define MS_PER_S     1000
`define LB_PER_KG_Q16 64'sd144481
`endif

/* File: include/sg_tare_pkg.sv */
// shared types of the strain gauge readout and tare block
package sg_tare_pkg;
  typedef struct packed {
    logic              valid;
    logic [1:0]        ch;
    logic signed [23:0] data;
  } sample_t;
  typedef struct packed {
    logic       enable;
    logic [2:0] filt;
    logic [3:0] rate;
    logic [2:0] gain;
    logic       burnout;
  } adc_cfg_t;
  typedef enum logic [3:0] {
    FB_IDLE  = 4'b0001,
    FB_LONG  = 4'b0010,
    FB_PULSE = 4'b0100,
    FB_GAP   = 4'b1000
  } fb_state_t;
endpackage

/* File: rtl/sg_tare.sv */
// load cell readout, scaling, filtering and tare/calibration sequencer
// Functional notes
// - global enable stops all conversions
// - filter select sinc1..4 or single-cycle fir
// - data rate selects 60..40000 sps sample pace
// - gain select from 1 to 128
// - periodic open-wire check, interval at least 1s
// - check enable cleared suppresses open-wire check
// - weight from sensitivity and capacity per channel
// - units 0 kilograms, 1 pounds, default kilograms
// - autozero copies weight to offset; offset writable
// - averaging none, moving, repeating; constant sets depth
// - tare response normal, inverted, latched, inverted latched
// - tare input debounced by configurable time
// - feedback select none, digital output, interlock
// - calibration feedback overrides normal output control
// - entering calibration gives 750ms feedback pulse
// - tare operation gives n 250ms pulses
// - exiting calibration gives 750ms feedback pulse
// - long press toggles calibration once only
// - short presses in calibration count toward operation
// - short presses outside calibration are discarded
// - results staged in calibration committed only on its exit
// - network or tool tare requests accepted too
// - inter-press timeout ends count, runs operation
// - ops 1-4 zero channel, 5 all, 6 min, 7 max
// - min and max go to constant entries one, two
//
// The register offsets and the APB slave port were chosen for this implementation.
`include "sg_tare_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sg_tare #(
  parameter int CLK_HZ = 200000000
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire sg_tare_pkg::sample_t sample_i,
  output sg_tare_pkg::adc_cfg_t   adc_cfg_o,
  output logic                    conv_start_o,
  output logic                    burnout_o,
  input  wire logic               tare_pin_i,
  input  wire logic               dout_ctl_i,
  input  wire logic               ilk_ctl_i,
  output logic                    dout_o,
  output logic                    ilk_o,
  output logic                    cal_mode_o
);
  import sg_tare_pkg::*;
  localparam int MS_CYC = (CLK_HZ / 1000 < 1) ? 1 : CLK_HZ / 1000;

  // ==========================================================
  // register file
  logic [31:0] ctrl, tcfg, times, const1, const2;
  logic [15:0] burn_s;
  logic [31:0] sens [4];
  logic [31:0] cap [4];
  logic [8:0]  chcfg [4];
  logic signed [31:0] ofs [4];
  logic signed [31:0] gross [4];
  wire         wr_en  = psel_i & penable_i & pwrite_i & pready_o;
  wire         setup  = psel_i & ~penable_i;
  wire         in_ch  = paddr_i[7:6] == 2'h1;
  wire [1:0]   a_ch   = paddr_i[5:4];
  wire [1:0]   a_fld  = paddr_i[3:2];
  wire         in_wt  = paddr_i[7:4] == 4'h3;
  wire [1:0]   w_ch   = paddr_i[3:2];
  wire         mapped = in_ch || in_wt || paddr_i[7:5] == 3'h0;
  wire         al_ok  = paddr_i[1:0] == 2'h0;
  logic [31:0] rd_mux;

  // ==========================================================
  // tare state, some of it read back in the status register
  logic       cal, fb_on, tare_lvl;
  logic [2:0] press_cnt;
  logic [3:0] fb_pend;
  logic       ev_long;
  logic [2:0] ev_ops;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_ch) begin
      case (a_fld)
        `CH_SENS: rd_mux = sens[a_ch];
        `CH_CAP:  rd_mux = cap[a_ch];
        `CH_CFG:  rd_mux = {23'h000000, 1'b0, chcfg[a_ch][7:0]};
        default:  rd_mux = ofs[a_ch];
      endcase
    end else if (in_wt) begin
      rd_mux = gross[w_ch] - ofs[w_ch];
    end else begin
      case (paddr_i)
        `OFF_CTRL:   rd_mux = ctrl;
        `OFF_BURN:   rd_mux = {16'h0000, burn_s};
        `OFF_TCFG:   rd_mux = tcfg;
        `OFF_TIMES:  rd_mux = times;
        `OFF_STAT:   rd_mux = {21'h000000, press_cnt, 4'h0, fb_on, tare_lvl,
                               burnout_o, cal};
        `OFF_CONST1: rd_mux = const1;
        `OFF_CONST2: rd_mux = const2;
        default:     rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // answer one cycle after setup; unmapped or misaligned gives pslverr
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~(mapped & al_ok);
      prdata_o  <= (setup & ~pwrite_i & mapped & al_ok) ? rd_mux : 32'h0000_0000;
    end
  end

  wire wr_ok = wr_en & mapped & al_ok;
  wire tool_op  = wr_ok && paddr_i == `OFF_CMD && pwdata_i[0];
  wire discard  = wr_ok && paddr_i == `OFF_CMD && pwdata_i[4];

  // ==========================================================
  // converter settings, sample pacing and open-wire check
  function automatic int rate_sps(input logic [3:0] s);
    case (s)
      4'h0: rate_sps = 60;
      4'h1: rate_sps = 100;
      4'h2: rate_sps = 400;
      4'h3: rate_sps = 1200;
      4'h4: rate_sps = 2400;
      4'h5: rate_sps = 4800;
      4'h6: rate_sps = 9600;
      4'h7: rate_sps = 19200;
      4'h8: rate_sps = 38400;
      default: rate_sps = 40000;
    endcase
  endfunction
  wire [31:0] rate_per = 32'(CLK_HZ / rate_sps(ctrl[7:4]));
  logic [31:0] rate_cnt;
  logic [31:0] ms_cnt;
  logic        ms_tick;
  logic [9:0]  ms_in_s;
  logic [15:0] sec_cnt;
  wire [15:0]  burn_int = (burn_s == 16'h0000) ? 16'h0001 : burn_s;
  wire         conv_due = rate_cnt + 32'h1 >= rate_per;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_cnt == 32'(MS_CYC - 1);
      ms_cnt  <= (ms_cnt == 32'(MS_CYC - 1)) ? 32'h0 : ms_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rate_cnt     <= 32'h0;
      conv_start_o <= 1'b0;
      adc_cfg_o    <= '0;
    end else begin
      rate_cnt     <= (conv_due || !ctrl[0]) ? 32'h0 : rate_cnt + 32'h1;
      conv_start_o <= ctrl[0] & conv_due;
      adc_cfg_o    <= {ctrl[0], ctrl[3:1], ctrl[7:4], ctrl[10:8], ctrl[11]};
    end
  end

  // check is held from its due second until the next conversion starts
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ms_in_s   <= 10'h000;
      sec_cnt   <= 16'h0000;
      burnout_o <= 1'b0;
    end else begin
      if (ms_tick) begin
        ms_in_s <= (ms_in_s == 10'(`MS_PER_S - 1)) ? 10'h000 : ms_in_s + 10'h001;
        if (ms_in_s == 10'(`MS_PER_S - 1)) begin
          if (sec_cnt + 16'h0001 >= burn_int) begin
            sec_cnt   <= 16'h0000;
            burnout_o <= ctrl[11] & ctrl[0];
          end else begin
            sec_cnt <= sec_cnt + 16'h0001;
          end
        end
      end
      if (conv_start_o && burnout_o) burnout_o <= 1'b0;
    end
  end

  // ==========================================================
  // scaling: weight = reading * capacity / sensitivity, then units
  wire [1:0]  s_ch  = sample_i.ch;
  wire        s_ok  = sample_i.valid & ctrl[0] & ~burnout_o;
  wire signed [63:0] prod = 64'(sample_i.data) * $signed({32'h0, cap[s_ch]});
  wire signed [63:0] kg   = (sens[s_ch] == 32'h0) ? 64'sh0
                            : prod / $signed({32'h0, sens[s_ch]});
  wire signed [63:0] lb   = (kg * `LB_PER_KG_Q16) >>> 16;
  wire signed [31:0] w_u  = chcfg[s_ch][0] ? 32'(lb) : 32'(kg);

  // ==========================================================
  // averaging: moving sum over 2^k samples or block average of 2^k
  logic signed [31:0] fbuf [4][8];
  logic signed [34:0] fsum [4];
  logic [2:0]         fidx [4];
  wire [1:0]          ftype = chcfg[s_ch][2:1];
  wire [1:0]          fk    = chcfg[s_ch][4:3];
  wire [2:0]          fmask = 3'((4'h1 << fk) - 4'h1);
  wire signed [34:0]  mv_sum = fsum[s_ch] + 35'(w_u) - 35'(fbuf[s_ch][fidx[s_ch]]);
  wire signed [34:0]  rp_sum = fsum[s_ch] + 35'(w_u);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int c = 0; c < 4; c++) begin
        gross[c] <= 32'sh0;
        fsum[c]  <= 35'sh0;
        fidx[c]  <= 3'h0;
        for (int i = 0; i < 8; i++) fbuf[c][i] <= 32'sh0;
      end
    end else if (s_ok) begin
      case (ftype)
        2'h1: begin
          fbuf[s_ch][fidx[s_ch]] <= w_u;
          fsum[s_ch]  <= mv_sum;
          fidx[s_ch]  <= (fidx[s_ch] + 3'h1) & fmask;
          gross[s_ch] <= 32'(mv_sum >>> fk);
        end
        2'h2: begin
          if (fidx[s_ch] == fmask) begin
            gross[s_ch] <= 32'(rp_sum >>> fk);
            fsum[s_ch]  <= 35'sh0;
            fidx[s_ch]  <= 3'h0;
          end else begin
            fsum[s_ch] <= rp_sum;
            fidx[s_ch] <= fidx[s_ch] + 3'h1;
          end
        end
        default: gross[s_ch] <= w_u;
      endcase
    end
  end

  // ==========================================================
  // tare input: synchroniser, debounce, response mode
  logic        t_s1, t_s2, t_stab, t_stab_d, latch;
  logic [7:0]  deb_ms;
  wire  [1:0]  resp  = tcfg[1:0];
  wire         t_pol = t_stab ^ resp[0];
  wire         t_rise = (t_stab ^ resp[0]) & ~(t_stab_d ^ resp[0]);
  wire         pressed = resp[1] ? latch : t_pol;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      t_s1 <= 1'b0;
      t_s2 <= 1'b0;
      t_stab <= 1'b0;
      t_stab_d <= 1'b0;
      deb_ms <= 8'h00;
      latch <= 1'b0;
    end else begin
      t_s1 <= tare_pin_i;
      t_s2 <= t_s1;
      t_stab_d <= t_stab;
      if (t_s2 == t_stab) begin
        deb_ms <= 8'h00;
      end else if (deb_ms >= tcfg[15:8]) begin
        t_stab <= t_s2;
        deb_ms <= 8'h00;
      end else if (ms_tick) begin
        deb_ms <= deb_ms + 8'h01;
      end
      if (t_rise) latch <= ~latch;
    end
  end

  // ==========================================================
  // press timing and calibration sequencer
  logic        prs_d, long_done, gap_run;
  logic [15:0] hold_ms, gap_ms;
  logic [3:0]  pz;
  logic signed [31:0] pofs [4];
  logic signed [31:0] pmin, pmax;
  logic        pmin_v, pmax_v;
  wire signed [31:0] total = (gross[0] - ofs[0]) + (gross[1] - ofs[1])
                           + (gross[2] - ofs[2]) + (gross[3] - ofs[3]);
  wire         long_hit = pressed && !long_done && hold_ms >= times[15:0];
  wire         release_short = prs_d && !pressed && !long_done;
  wire         gap_end = gap_run && gap_ms >= times[31:16];
  wire         op_go = (gap_end && cal) || tool_op;
  wire [2:0]   op = tool_op ? pwdata_i[3:1] : press_cnt;
  wire         direct = tool_op && !cal;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prs_d <= 1'b0;
      long_done <= 1'b0;
      gap_run <= 1'b0;
      hold_ms <= 16'h0000;
      gap_ms <= 16'h0000;
      press_cnt <= 3'h0;
      cal <= 1'b0;
      ev_long <= 1'b0;
      ev_ops <= 3'h0;
      tare_lvl <= 1'b0;
    end else begin
      prs_d <= pressed;
      tare_lvl <= pressed;
      ev_long <= 1'b0;
      ev_ops <= 3'h0;
      if (!pressed) begin
        hold_ms <= 16'h0000;
        long_done <= 1'b0;
      end else if (ms_tick && hold_ms != 16'hFFFF) begin
        hold_ms <= hold_ms + 16'h0001;
      end
      if (long_hit) begin
        cal <= ~cal;
        long_done <= 1'b1;
        ev_long <= 1'b1;
        gap_run <= 1'b0;
        press_cnt <= 3'h0;
      end else if (release_short && cal) begin
        if (press_cnt != 3'h7) press_cnt <= press_cnt + 3'h1;
        gap_run <= 1'b1;
        gap_ms <= 16'h0000;
      end else if (gap_end) begin
        gap_run <= 1'b0;
        press_cnt <= 3'h0;
      end else if (gap_run && ms_tick && !pressed) begin
        gap_ms <= gap_ms + 16'h0001;
      end
      // a short release outside calibration changes nothing
      if (op_go && !long_hit) ev_ops <= op;
    end
  end

  // ==========================================================
  // registers written by software and by committed tare results
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl <= `CTRL_RST;
      burn_s <= `BURN_RST;
      tcfg <= `TCFG_RST;
      times <= `TIMES_RST;
      const1 <= 32'h0000_0000;
      const2 <= 32'h0000_0000;
      pz <= 4'h0;
      pmin_v <= 1'b0;
      pmax_v <= 1'b0;
      pmin <= 32'sh0;
      pmax <= 32'sh0;
      for (int c = 0; c < 4; c++) begin
        sens[c] <= `SENS_RST;
        cap[c] <= `CAP_RST;
        chcfg[c] <= 9'h000;
        ofs[c] <= 32'sh0;
        pofs[c] <= 32'sh0;
      end
    end else begin
      if (wr_ok && in_ch) begin
        case (a_fld)
          `CH_SENS: sens[a_ch] <= pwdata_i;
          `CH_CAP:  cap[a_ch] <= pwdata_i;
          `CH_CFG:  chcfg[a_ch] <= {1'b0, pwdata_i[7:0]};
          default:  ofs[a_ch] <= pwdata_i;
        endcase
        if (a_fld == `CH_CFG && pwdata_i[8]) ofs[a_ch] <= gross[a_ch];
      end else if (wr_ok) begin
        case (paddr_i)
          `OFF_CTRL:   ctrl <= {20'h00000, pwdata_i[11:0]};
          `OFF_BURN:   burn_s <= pwdata_i[15:0];
          `OFF_TCFG:   tcfg <= {16'h0000, pwdata_i[15:8], 4'h0, pwdata_i[3:0]};
          `OFF_TIMES:  times <= pwdata_i;
          `OFF_CONST1: const1 <= pwdata_i;
          `OFF_CONST2: const2 <= pwdata_i;
          default: ;
        endcase
      end
      if (op_go) begin
        for (int c = 0; c < 4; c++) begin
          if (op == 3'(c + 1) || op == 3'h5) begin
            if (direct) ofs[c] <= gross[c];
            else begin
              pofs[c] <= gross[c];
              pz[c] <= 1'b1;
            end
          end
        end
        if (op == 3'h6) begin
          if (direct) const1 <= total;
          else begin
            pmin <= total;
            pmin_v <= 1'b1;
          end
        end
        if (op == 3'h7) begin
          if (direct) const2 <= total;
          else begin
            pmax <= total;
            pmax_v <= 1'b1;
          end
        end
      end
      // only a proper exit commits; entry or abort drops the staged values
      if (long_hit && cal) begin
        for (int c = 0; c < 4; c++) if (pz[c]) ofs[c] <= pofs[c];
        if (pmin_v) const1 <= pmin;
        if (pmax_v) const2 <= pmax;
      end
      if (long_hit || discard) begin
        pz <= 4'h0;
        pmin_v <= 1'b0;
        pmax_v <= 1'b0;
      end
    end
  end

  // ==========================================================
  // feedback pulse generator and output override
  fb_state_t   fb_st;
  logic [9:0]  fb_ms;
  logic        fb_lreq;
  wire  [1:0]  fb_sel = tcfg[3:2];
  wire  [9:0]  fb_len = (fb_st == FB_LONG) ? 10'(`FB_LONG_MS) : 10'(`FB_PULSE_MS);
  wire         fb_done = ms_tick && fb_ms + 10'h001 >= fb_len;
  wire         ovr = cal || ev_long || fb_lreq || fb_st != FB_IDLE;
  wire         fb_take = fb_st == FB_IDLE && !fb_lreq && fb_pend != 4'h0;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fb_st <= FB_IDLE;
      fb_ms <= 10'h000;
      fb_lreq <= 1'b0;
      fb_pend <= 4'h0;
      fb_on <= 1'b0;
      dout_o <= 1'b0;
      ilk_o <= 1'b0;
      cal_mode_o <= 1'b0;
    end else begin
      cal_mode_o <= cal;
      fb_on <= fb_st == FB_LONG || fb_st == FB_PULSE;
      fb_ms <= (fb_st == FB_IDLE || fb_done) ? 10'h000 :
               (ms_tick ? fb_ms + 10'h001 : fb_ms);
      // requests are set after the take so a new one is never lost
      case (fb_st)
        FB_IDLE: begin
          if (fb_lreq) begin
            fb_st <= FB_LONG;
            fb_lreq <= 1'b0;
          end else if (fb_pend != 4'h0) begin
            fb_st <= FB_PULSE;
            fb_pend <= fb_pend - 4'h1;
          end
        end
        FB_LONG:  if (fb_done) fb_st <= FB_GAP;
        FB_PULSE: if (fb_done) fb_st <= FB_GAP;
        FB_GAP:   if (fb_done) fb_st <= FB_IDLE;
        default:  fb_st <= FB_IDLE;
      endcase
      if (fb_sel == 2'h0) begin
        fb_lreq <= 1'b0;
        fb_pend <= 4'h0;
      end else begin
        if (ev_long) fb_lreq <= 1'b1;
        if (ev_ops != 3'h0) fb_pend <= fb_pend + {1'b0, ev_ops} - {3'h0, fb_take};
      end
      dout_o <= (fb_sel == 2'h1 && ovr) ? fb_on : dout_ctl_i;
      ilk_o  <= (fb_sel == 2'h2 && ovr) ? fb_on : ilk_ctl_i;
    end
  end
endmodule
`default_nettype wire
